// file: core/spi_mem_pkg.sv
/*
  Shared constants and types for the serial byte memory and its SPI master.
  Assumes both ends run on one 50 MHz system clock.
*/
package spi_mem_pkg;

  // Array geometry
  localparam int          MEM_WORDS = 16384;
  localparam int          MEM_AW    = 14;

  // Op-codes
  localparam logic [7:0]  OP_ARM      = 8'h06;
  localparam logic [7:0]  OP_DISARM   = 8'h04;
  localparam logic [7:0]  OP_STAT_RD  = 8'h05;
  localparam logic [7:0]  OP_STAT_WR  = 8'h01;
  localparam logic [7:0]  OP_READ     = 8'h03;
  localparam logic [7:0]  OP_WRITE    = 8'h02;

  // Status field positions
  localparam int          ST_LOCK_BIT     = 7;
  localparam int          ST_SPARE_HI     = 6;
  localparam int          ST_SPARE_LO     = 4;
  localparam int          ST_GUARD_HI_BIT = 3;
  localparam int          ST_GUARD_LO_BIT = 2;
  localparam int          ST_ARM_BIT      = 1;
  localparam int          ST_ZERO_BIT     = 0;
  localparam logic [7:0]  ST_RESET        = 8'h00;

  // Region-guard lower bounds
  localparam logic [13:0] GUARD_QUARTER_BASE = 14'h3000;
  localparam logic [13:0] GUARD_HALF_BASE    = 14'h2000;
  localparam logic [1:0]  GUARD_NONE         = 2'h0;
  localparam logic [1:0]  GUARD_QUARTER      = 2'h1;
  localparam logic [1:0]  GUARD_HALF         = 2'h2;

  // Master register map
  localparam logic [7:0]  OFS_CTRL = 8'h00;
  localparam logic [7:0]  OFS_TX   = 8'h04;
  localparam logic [7:0]  OFS_RX   = 8'h08;
  localparam int          CTRL_MODE3_BIT = 0;
  localparam int          CTRL_HOLD_BIT  = 1;
  localparam int          CTRL_WP_BIT    = 2;
  localparam logic [2:0]  CTRL_RESET     = 3'h6;
  localparam int          TX_LAST_BIT    = 8;
  localparam int          RX_BUSY_BIT    = 8;
  localparam int          RX_SEL_BIT     = 9;

  // Serial clock made by the master
  localparam int          SYS_PERIOD_NS   = 20;
  localparam int          SCK_HALF_NS     = 200;
  localparam logic [7:0]  SCK_HALF_CYCLES =
    8'((SCK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

  typedef enum logic [2:0] {
    P_OP, P_ADDR, P_DATA_RD, P_DATA_WR, P_STAT_RD, P_STAT_WR, P_IGNORE
  } dev_phase_t;

  typedef enum logic [1:0] {H_IDLE, H_LO, H_HI, H_TAIL} host_phase_t;

endpackage : spi_mem_pkg

// file: core/spi_link_if.sv
/*
  Serial link between the memory end and the master end.
  Assumes the bench resolves the data-out wire from so_out and so_oe_n.
*/
`timescale 1ns/1ps
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic hold_n;
  logic wp_n;
  logic so_out;
  logic so_oe_n;

  modport device (
    input  cs_n,
    input  sck,
    input  si,
    input  hold_n,
    input  wp_n,
    output so_out,
    output so_oe_n
  );

  modport host (
    output cs_n,
    output sck,
    output si,
    output hold_n,
    output wp_n,
    input  so_out,
    input  so_oe_n
  );
endinterface : spi_link_if

// file: core/spi_mem_device.sv
/*
  Serial slave front end and 16K x 8 array of the nonvolatile byte memory.
  Assumes link pins are asynchronous to CLK_SYS and that RST is power-on.
*/
// Overview of operation
// - Select high: standby, output floated, inputs ignored
// - Master lowers select before first op-code bit
// - Pause low: transfer frozen, output floated
// - Master keeps select low during pause
// - Sample on rising edge, shift out falling
// - Modes 0 and 3 both supported
// - Op-code, address, data in; array, status out
// - Array holds 16384 bytes
// - Writes finish at serial speed, no busy
// - Bit 7 lock enable, readable and writable
// - Status writes gated by guard pin and lock
// - Bits 6..4 spare, writable, reset 000
// - Bits 3..2 select guarded array region
// - Bit 1 arm latch, set/cleared by commands
// - Status read shows latch, status write data cannot set it
// - Latch clears at reset, disarm, write end
// - Bit 0 always reads zero
// - Six eight-bit op-codes, others not sent
// - Guard codes: none, quarter, half, all
// - Latch clear blocks all writes
// - 14-bit address, auto-increment with wrap
`timescale 1ns/1ps
module spi_mem_device (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  spi_link_if.device       LINK,
  output logic      [7:0]  STATUS,
  output logic             SELECTED
);

  typedef struct packed {
    logic [2:0]                  cs_sy;
    logic [2:0]                  sck_sy;
    logic [1:0]                  si_sy;
    logic [1:0]                  hold_sy;
    logic [1:0]                  wp_sy;
    spi_mem_pkg::dev_phase_t     phase;
    logic [2:0]                  bit_cnt;
    logic [7:0]                  in_sh;
    logic                        addr_second;
    logic                        is_read;
    logic [spi_mem_pkg::MEM_AW-1:0] addr;
    logic [7:0]                  out_sh;
    logic                        write_rec;
    logic                        lock;
    logic [2:0]                  spare;
    logic [1:0]                  guard;
    logic                        arm;
    logic                        so;
    logic                        so_oe_n;
    logic [7:0]                  status_q;
    logic                        selected;
  } dev_state_t;

  dev_state_t                       st_ff;
  dev_state_t                       nxt_st;
  logic [7:0]                       mem_q [spi_mem_pkg::MEM_WORDS];
  logic                             mem_we;
  logic [spi_mem_pkg::MEM_AW-1:0]   mem_wa;
  logic [7:0]                       mem_wd;

  function automatic logic guarded(input logic [1:0] g,
                                   input logic [spi_mem_pkg::MEM_AW-1:0] a);
    unique case (g)
      spi_mem_pkg::GUARD_NONE:    guarded = 1'b0;
      spi_mem_pkg::GUARD_QUARTER: guarded = (a >= spi_mem_pkg::GUARD_QUARTER_BASE);
      spi_mem_pkg::GUARD_HALF:    guarded = (a >= spi_mem_pkg::GUARD_HALF_BASE);
      default:                    guarded = 1'b1;
    endcase
  endfunction : guarded

  function automatic logic [7:0] status_word(input dev_state_t s);
    status_word                             = 8'h00;
    status_word[spi_mem_pkg::ST_LOCK_BIT]   = s.lock;
    status_word[spi_mem_pkg::ST_SPARE_HI:spi_mem_pkg::ST_SPARE_LO] = s.spare;
    status_word[spi_mem_pkg::ST_GUARD_HI_BIT:spi_mem_pkg::ST_GUARD_LO_BIT] = s.guard;
    status_word[spi_mem_pkg::ST_ARM_BIT]    = s.arm;
    status_word[spi_mem_pkg::ST_ZERO_BIT]   = 1'b0;
  endfunction : status_word

  always_comb begin
    logic                           sel;
    logic                           sel_prev;
    logic                           sck_rise;
    logic                           sck_fall;
    logic                           held;
    logic [7:0]                     byte_in;
    logic [spi_mem_pkg::MEM_AW-1:0] addr_inc;
    sel      = 1'b0;
    sel_prev = 1'b0;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    held     = 1'b0;
    byte_in  = 8'h00;
    addr_inc = '0;
    nxt_st   = st_ff;
    mem_we   = 1'b0;
    mem_wa   = st_ff.addr;
    mem_wd   = 8'h00;

    // Pins come from the master's domain
    nxt_st.cs_sy   = {st_ff.cs_sy[1:0], ~LINK.cs_n};
    nxt_st.sck_sy  = {st_ff.sck_sy[1:0], LINK.sck};
    nxt_st.si_sy   = {st_ff.si_sy[0], LINK.si};
    nxt_st.hold_sy = {st_ff.hold_sy[0], LINK.hold_n};
    nxt_st.wp_sy   = {st_ff.wp_sy[0], LINK.wp_n};

    sel      = st_ff.cs_sy[1];
    sel_prev = st_ff.cs_sy[2];
    sck_rise = st_ff.sck_sy[1] & ~st_ff.sck_sy[2];
    sck_fall = ~st_ff.sck_sy[1] & st_ff.sck_sy[2];
    held     = ~st_ff.hold_sy[1];
    byte_in  = {st_ff.in_sh[6:0], st_ff.si_sy[1]};
    addr_inc = st_ff.addr + 1'b1;  // Wraps top to zero

    if (!sel) begin
      // Partial op-code never reaches decode
      nxt_st.phase       = spi_mem_pkg::P_OP;
      nxt_st.bit_cnt     = 3'h0;
      nxt_st.addr_second = 1'b0;
      nxt_st.write_rec   = 1'b0;
      if (sel_prev && st_ff.write_rec) begin
        nxt_st.arm = 1'b0;
      end
    end else if (!held) begin
      if (sck_rise) begin
        nxt_st.in_sh   = byte_in;
        nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
        if (st_ff.bit_cnt == 3'h7) begin
          unique case (st_ff.phase)
            spi_mem_pkg::P_OP: begin
              unique case (byte_in)
                spi_mem_pkg::OP_ARM: begin
                  nxt_st.arm   = 1'b1;
                  nxt_st.phase = spi_mem_pkg::P_IGNORE;
                end
                spi_mem_pkg::OP_DISARM: begin
                  nxt_st.arm   = 1'b0;
                  nxt_st.phase = spi_mem_pkg::P_IGNORE;
                end
                spi_mem_pkg::OP_STAT_RD: begin
                  nxt_st.out_sh = status_word(st_ff);
                  nxt_st.phase  = spi_mem_pkg::P_STAT_RD;
                end
                spi_mem_pkg::OP_STAT_WR: begin
                  nxt_st.write_rec = 1'b1;
                  nxt_st.phase     = spi_mem_pkg::P_STAT_WR;
                end
                spi_mem_pkg::OP_READ: begin
                  nxt_st.is_read = 1'b1;
                  nxt_st.phase   = spi_mem_pkg::P_ADDR;
                end
                spi_mem_pkg::OP_WRITE: begin
                  nxt_st.is_read   = 1'b0;
                  nxt_st.write_rec = 1'b1;
                  nxt_st.phase     = spi_mem_pkg::P_ADDR;
                end
                default: begin
                  nxt_st.phase = spi_mem_pkg::P_IGNORE;
                end
              endcase
            end
            spi_mem_pkg::P_ADDR: begin
              if (!st_ff.addr_second) begin
                // Top two address bits are dropped
                nxt_st.addr[13:8]  = byte_in[5:0];
                nxt_st.addr_second = 1'b1;
              end else begin
                nxt_st.addr[7:0] = byte_in;
                if (st_ff.is_read) begin
                  nxt_st.out_sh = mem_q[{st_ff.addr[13:8], byte_in}];
                  nxt_st.phase  = spi_mem_pkg::P_DATA_RD;
                end else begin
                  nxt_st.phase = spi_mem_pkg::P_DATA_WR;
                end
              end
            end
            spi_mem_pkg::P_DATA_WR: begin
              // Array takes the byte on this edge, no busy time
              if (st_ff.arm && !guarded(st_ff.guard, st_ff.addr)) begin
                mem_we = 1'b1;
                mem_wd = byte_in;
              end
              nxt_st.addr = addr_inc;
            end
            spi_mem_pkg::P_DATA_RD: begin
              nxt_st.addr   = addr_inc;
              nxt_st.out_sh = mem_q[addr_inc];
            end
            spi_mem_pkg::P_STAT_RD: begin
              nxt_st.out_sh = status_word(st_ff);  // Repeats while clocked
            end
            spi_mem_pkg::P_STAT_WR: begin
              // Latch and bit 0 are not written
              if (st_ff.arm && !(st_ff.lock && !st_ff.wp_sy[1])) begin
                nxt_st.lock  = byte_in[spi_mem_pkg::ST_LOCK_BIT];
                nxt_st.spare = byte_in[spi_mem_pkg::ST_SPARE_HI:spi_mem_pkg::ST_SPARE_LO];
                nxt_st.guard = byte_in[spi_mem_pkg::ST_GUARD_HI_BIT:
                                       spi_mem_pkg::ST_GUARD_LO_BIT];
              end
              nxt_st.phase = spi_mem_pkg::P_IGNORE;
            end
            default: begin
              nxt_st.phase = spi_mem_pkg::P_IGNORE;
            end
          endcase
        end
      end
      if (sck_fall && (st_ff.phase == spi_mem_pkg::P_DATA_RD ||
                       st_ff.phase == spi_mem_pkg::P_STAT_RD)) begin
        nxt_st.so     = st_ff.out_sh[7];
        nxt_st.out_sh = {st_ff.out_sh[6:0], 1'b0};
      end
    end

    // Drive only while selected, not paused, and in a read phase
    nxt_st.so_oe_n = ~(sel && !held &&
                       (nxt_st.phase == spi_mem_pkg::P_DATA_RD ||
                        nxt_st.phase == spi_mem_pkg::P_STAT_RD));
    nxt_st.status_q = status_word(nxt_st);
    nxt_st.selected = sel;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      // Reset stands for first power-up; spare bits at factory 000
      st_ff <= '{cs_sy: 3'h0, sck_sy: 3'h0, si_sy: 2'h0, hold_sy: 2'h3, wp_sy: 2'h3,
                 phase: spi_mem_pkg::P_OP, bit_cnt: 3'h0, in_sh: 8'h00,
                 addr_second: 1'b0, is_read: 1'b0, addr: 14'h0000, out_sh: 8'h00,
                 write_rec: 1'b0, lock: 1'b0, spare: 3'h0, guard: 2'h0,
                 arm: 1'b0, so: 1'b0, so_oe_n: 1'b1,
                 status_q: spi_mem_pkg::ST_RESET, selected: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Array is not cleared by reset: it models retained contents
  always_ff @(posedge CLK_SYS) begin
    if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  assign LINK.so_out  = st_ff.so;
  assign LINK.so_oe_n = st_ff.so_oe_n;
  assign STATUS       = st_ff.status_q;
  assign SELECTED     = st_ff.selected;

endmodule : spi_mem_device

// file: core/spi_mem_host.sv
/*
  SPI master end for the byte memory, steered by software over APB.
  Assumes an APB master on CLK_SYS; the serial clock is divided from it.
*/
`timescale 1ns/1ps
module spi_mem_host (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  spi_link_if.host         LINK
);

  typedef struct packed {
    logic [1:0]               so_sy;
    logic [1:0]               oe_sy;
    spi_mem_pkg::host_phase_t phase;
    logic [7:0]               cnt;
    logic [2:0]               bit_cnt;
    logic [7:0]               tx_sh;
    logic [7:0]               rx_sh;
    logic [7:0]               rx_q;
    logic                     end_after;
    logic                     mode3;
    logic                     hold_n;
    logic                     wp_n;
    logic                     cs_n;
    logic                     sck;
    logic                     mosi;
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              prdata;
  } host_state_t;

  host_state_t st_ff;
  host_state_t nxt_st;

  always_comb begin
    logic access;
    logic busy;
    logic half_done;
    access    = PSEL & PENABLE;
    busy      = (st_ff.phase != spi_mem_pkg::H_IDLE);
    half_done = (st_ff.cnt == spi_mem_pkg::SCK_HALF_CYCLES - 8'h01);
    nxt_st    = st_ff;
    nxt_st.so_sy = {st_ff.so_sy[0], LINK.so_out};
    nxt_st.oe_sy = {st_ff.oe_sy[0], LINK.so_oe_n};
    nxt_st.cnt   = st_ff.cnt + 8'h01;

    unique case (st_ff.phase)
      spi_mem_pkg::H_IDLE: begin
        nxt_st.cnt = 8'h00;
        if (st_ff.cs_n) begin
          nxt_st.sck = st_ff.mode3;  // Idle level picks mode 0 or 3
        end
      end
      spi_mem_pkg::H_LO: begin
        if (half_done) begin
          nxt_st.cnt   = 8'h00;
          nxt_st.sck   = 1'b1;
          // Released line shows the inverse, so stale bits cannot pass
          nxt_st.rx_sh = {st_ff.rx_sh[6:0], st_ff.so_sy[1] ^ st_ff.oe_sy[1]};
          nxt_st.phase = spi_mem_pkg::H_HI;
        end
      end
      spi_mem_pkg::H_HI: begin
        if (half_done) begin
          nxt_st.cnt = 8'h00;
          if (st_ff.bit_cnt == 3'h7) begin
            nxt_st.rx_q  = st_ff.rx_sh;
            nxt_st.sck   = st_ff.mode3;
            nxt_st.phase = st_ff.end_after ? spi_mem_pkg::H_TAIL : spi_mem_pkg::H_IDLE;
          end else begin
            // Launch on the falling edge
            nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
            nxt_st.tx_sh   = {st_ff.tx_sh[6:0], 1'b0};
            nxt_st.mosi    = st_ff.tx_sh[6];
            nxt_st.sck     = 1'b0;
            nxt_st.phase   = spi_mem_pkg::H_LO;
          end
        end
      end
      spi_mem_pkg::H_TAIL: begin
        if (half_done) begin
          nxt_st.cnt   = 8'h00;
          nxt_st.cs_n  = 1'b1;
          nxt_st.phase = spi_mem_pkg::H_IDLE;
        end
      end
    endcase

    // Answer one cycle into access; a byte write waits for the engine
    nxt_st.pready = 1'b0;
    if (access && !st_ff.pready && !(PWRITE && PADDR == spi_mem_pkg::OFS_TX && busy)) begin
      nxt_st.pready  = 1'b1;
      nxt_st.pslverr = !(PADDR == spi_mem_pkg::OFS_CTRL || PADDR == spi_mem_pkg::OFS_TX ||
                         PADDR == spi_mem_pkg::OFS_RX);
      nxt_st.prdata  = 32'h0000_0000;
      if (!PWRITE && PADDR == spi_mem_pkg::OFS_CTRL) begin
        nxt_st.prdata[spi_mem_pkg::CTRL_MODE3_BIT] = st_ff.mode3;
        nxt_st.prdata[spi_mem_pkg::CTRL_HOLD_BIT]  = st_ff.hold_n;
        nxt_st.prdata[spi_mem_pkg::CTRL_WP_BIT]    = st_ff.wp_n;
      end else if (!PWRITE && PADDR == spi_mem_pkg::OFS_RX) begin
        nxt_st.prdata[7:0]                      = st_ff.rx_q;
        nxt_st.prdata[spi_mem_pkg::RX_BUSY_BIT] = busy;
        nxt_st.prdata[spi_mem_pkg::RX_SEL_BIT]  = ~st_ff.cs_n;
      end
    end

    // Writes act only at the edge that completes the transfer
    if (access && st_ff.pready && PWRITE) begin
      if (PADDR == spi_mem_pkg::OFS_CTRL) begin
        // Pause and guard pins are software's; keep select low while paused
        nxt_st.mode3  = PWDATA[spi_mem_pkg::CTRL_MODE3_BIT];
        nxt_st.hold_n = PWDATA[spi_mem_pkg::CTRL_HOLD_BIT];
        nxt_st.wp_n   = PWDATA[spi_mem_pkg::CTRL_WP_BIT];
      end else if (PADDR == spi_mem_pkg::OFS_TX) begin
        // Select falls a half period before the first rising edge
        nxt_st.cs_n      = 1'b0;
        nxt_st.sck       = 1'b0;
        nxt_st.tx_sh     = PWDATA[7:0];
        nxt_st.mosi      = PWDATA[7];
        nxt_st.end_after = PWDATA[spi_mem_pkg::TX_LAST_BIT];
        nxt_st.bit_cnt   = 3'h0;
        nxt_st.cnt       = 8'h00;
        nxt_st.phase     = spi_mem_pkg::H_LO;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st_ff <= '{so_sy: 2'h0, oe_sy: 2'h3, phase: spi_mem_pkg::H_IDLE, cnt: 8'h00, bit_cnt: 3'h0,
                 tx_sh: 8'h00, rx_sh: 8'h00, rx_q: 8'h00, end_after: 1'b0,
                 mode3: spi_mem_pkg::CTRL_RESET[spi_mem_pkg::CTRL_MODE3_BIT],
                 hold_n: spi_mem_pkg::CTRL_RESET[spi_mem_pkg::CTRL_HOLD_BIT],
                 wp_n: spi_mem_pkg::CTRL_RESET[spi_mem_pkg::CTRL_WP_BIT],
                 cs_n: 1'b1, sck: 1'b0, mosi: 1'b0, pready: 1'b0, pslverr: 1'b0,
                 prdata: 32'h0000_0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign PRDATA      = st_ff.prdata;
  assign PREADY      = st_ff.pready;
  assign PSLVERR     = st_ff.pslverr;
  assign LINK.cs_n   = st_ff.cs_n;
  assign LINK.sck    = st_ff.sck;
  assign LINK.si     = st_ff.mosi;
  assign LINK.hold_n = st_ff.hold_n;
  assign LINK.wp_n   = st_ff.wp_n;

endmodule : spi_mem_host

// file: dv/spi_mem_chk.sv
/* Checker for the serial link between memory end and master end.
   Assumes it sits beside the link, sampled on CLK_SYS with RST. */
`timescale 1ns/1ps
module spi_mem_chk (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic so_out,
  input wire logic so_oe_n
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // Rising serial edges in this frame
  logic [7:0] rise_cnt_ff;
  always_ff @(posedge CLK_SYS) begin
    if (RST || cs_n) rise_cnt_ff <= 8'h00;
    else if ($rose(sck)) rise_cnt_ff <= rise_cnt_ff + 8'h01;
  end
  a_standby_floats: assert property (cs_n [*5] |-> so_oe_n)
    else $error("output driven while deselected");
  a_pause_floats: assert property (!hold_n [*5] |-> so_oe_n)
    else $error("output driven during pause");
  a_out_on_fall: assert property (!so_oe_n && !$past(so_oe_n) && $changed(so_out) |-> !sck)
    else $error("output changed while clock high");
  a_in_held_high: assert property (!cs_n && sck && $past(sck) |-> $stable(si))
    else $error("input bit moved while clock high");
  a_select_first: assert property ($fell(cs_n) |-> !sck [*8])
    else $error("clock moved too soon after select");
  a_high_phase: assert property ($rose(sck) && !cs_n |-> sck [*8])
    else $error("clock high phase too short");
  a_byte_units: assert property ($rose(cs_n) |-> rise_cnt_ff[2:0] == 3'h0)
    else $error("frame not whole bytes");
  a_drive_cause: assert property ($fell(so_oe_n) |-> !cs_n && hold_n)
    else $error("output enabled without active frame");
endmodule : spi_mem_chk

// file: dv/spi_nonvolatile_byte_memory_tb_top.sv
/* Bench for the serial memory and its APB-steered master.
   Assumes the core files are compiled first. */
`timescale 1ns/1ps
module spi_nonvolatile_byte_memory_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  status;
  logic        selected;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  b0;
  int          n_mismatch   = 0;
  int          total_checks = 0;
  spi_link_if link ();
  spi_mem_device spi_mem_device_inst (.CLK_SYS(clk_sys), .RST(rst), .LINK(link),
    .STATUS(status), .SELECTED(selected));
  spi_mem_host spi_mem_host_inst (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
  spi_mem_chk spi_mem_chk_inst (.CLK_SYS(clk_sys), .RST(rst), .cs_n(link.cs_n),
    .sck(link.sck), .si(link.si), .hold_n(link.hold_n), .so_out(link.so_out),
    .so_oe_n(link.so_oe_n));
  always #10 clk_sys = ~clk_sys;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 4000);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("FAIL apb ready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One byte out and in; waits for the engine to go idle
  task automatic xfer(input logic [7:0] b, input logic last);
    int n;
    apb(1'b1, spi_mem_pkg::OFS_TX, {23'h0, last, b});
    n = 0;
    do begin
      apb(1'b0, spi_mem_pkg::OFS_RX, 32'h0);
      n++;
    end while (rd[spi_mem_pkg::RX_BUSY_BIT] !== 1'b0 && n < 200);
    if (rd[spi_mem_pkg::RX_BUSY_BIT] !== 1'b0) begin
      n_mismatch++;
      $display("FAIL engine idle expected 0 seen %b", rd[spi_mem_pkg::RX_BUSY_BIT]);
    end
  endtask : xfer
  task automatic cmd(input logic [7:0] op);
    xfer(op, 1'b1);
  endtask : cmd
  task automatic stat(input logic [7:0] op, input logic [7:0] d);
    xfer(op, 1'b0);
    xfer(d, 1'b1);
  endtask : stat
  // Two data bytes; first received byte left in b0
  task automatic frame(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d);
    xfer(op, 1'b0);
    xfer(a[15:8], 1'b0);
    xfer(a[7:0], 1'b0);
    xfer(d[15:8], 1'b0);
    b0 = rd[7:0];
    xfer(d[7:0], 1'b1);
  endtask : frame
  task automatic rd_pair(input logic [15:0] a, input logic [15:0] exp);
    frame(spi_mem_pkg::OP_READ, a, 16'h0);
    check("array data", 32'(exp), {16'h0, b0, rd[7:0]});
  endtask : rd_pair
  task automatic conclude;
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    apb(1'b0, spi_mem_pkg::OFS_CTRL, 32'h0);
    check("ctrl reset", 32'h6, rd);
    apb(1'b0, 8'h0C, 32'h0);
    check("unmapped", 32'h1, {rd[30:0], err});
    stat(spi_mem_pkg::OP_STAT_RD, 8'h00);
    check("status reset", 32'h0, 32'(rd[7:0]));
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, spi_mem_pkg::OFS_CTRL, 32'h6 | m);
      cmd(spi_mem_pkg::OP_ARM);
      stat(spi_mem_pkg::OP_STAT_RD, 8'h00);
      check("armed", 32'h2, 32'(rd[7:0]));
      frame(spi_mem_pkg::OP_WRITE, 16'hC010 + 16'(m), 16'hA53C);
      stat(spi_mem_pkg::OP_STAT_RD, 8'h00);
      check("arm after write", 32'h0, 32'(rd[7:0]));
      frame(spi_mem_pkg::OP_WRITE, 16'h0010 + 16'(m), 16'hFFFF);
      rd_pair(16'h0010 + 16'(m), 16'hA53C);
    end
    // Array now holds A5 at 0010, A5 at 0011, 3C at 0012
    cmd(spi_mem_pkg::OP_ARM);
    frame(spi_mem_pkg::OP_WRITE, 16'hFFFF, 16'h1122);
    rd_pair(16'h3FFF, 16'h1122);
    cmd(spi_mem_pkg::OP_ARM);
    frame(spi_mem_pkg::OP_WRITE, 16'h2FFF, 16'h0033);
    cmd(spi_mem_pkg::OP_ARM);
    cmd(spi_mem_pkg::OP_DISARM);
    frame(spi_mem_pkg::OP_WRITE, 16'h0010, 16'h7777);
    rd_pair(16'h0010, 16'hA5A5);
    // Mode stays 3 across the pause; a mode change mid-frame would eat an edge
    xfer(spi_mem_pkg::OP_READ, 1'b0);
    xfer(8'h00, 1'b0);
    xfer(8'h11, 1'b0);
    apb(1'b1, spi_mem_pkg::OFS_CTRL, 32'h5);
    xfer(8'h00, 1'b0);
    apb(1'b1, spi_mem_pkg::OFS_CTRL, 32'h7);
    xfer(8'h00, 1'b1);
    check("read across pause", 32'hA5, 32'(rd[7:0]));
    cmd(spi_mem_pkg::OP_ARM);
    stat(spi_mem_pkg::OP_STAT_WR, 8'hFF);
    stat(spi_mem_pkg::OP_STAT_RD, 8'h00);
    check("status write", 32'hFC, 32'(rd[7:0]));
    cmd(spi_mem_pkg::OP_ARM);
    frame(spi_mem_pkg::OP_WRITE, 16'h3FFF, 16'h5555);
    rd_pair(16'h3FFF, 16'h1122);
    apb(1'b1, spi_mem_pkg::OFS_CTRL, 32'h2);
    cmd(spi_mem_pkg::OP_ARM);
    stat(spi_mem_pkg::OP_STAT_WR, 8'h00);
    stat(spi_mem_pkg::OP_STAT_RD, 8'h00);
    check("locked status", 32'hFC, 32'(rd[7:0]));
    apb(1'b1, spi_mem_pkg::OFS_CTRL, 32'h6);
    cmd(spi_mem_pkg::OP_ARM);
    stat(spi_mem_pkg::OP_STAT_WR, 8'h04);
    cmd(spi_mem_pkg::OP_ARM);
    frame(spi_mem_pkg::OP_WRITE, 16'h2FFF, 16'h6677);
    rd_pair(16'h2FFF, 16'h6633);
    cmd(spi_mem_pkg::OP_ARM);
    stat(spi_mem_pkg::OP_STAT_WR, 8'h08);
    cmd(spi_mem_pkg::OP_ARM);
    frame(spi_mem_pkg::OP_WRITE, 16'h2FFF, 16'h4444);
    rd_pair(16'h2FFF, 16'h6633);
    check("status port", 32'h08, 32'(status));
    conclude();
  end
  // Run needs about 21000 cycles
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    conclude();
  end
endmodule : spi_nonvolatile_byte_memory_tb_top
